// ---- core/spiee_device.sv ----
/*
 * Serial EEPROM end: 256 bytes, write latch, block lock, self-timed writes.
 * Assumes clk_i free running at 125 MHz and rst_i as power-on; the link clock
 * ticks only inside frames, so frame results are taken over by clk_i logic.
 */
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module spiee_device #(
    parameter int PUR_CYC_P = spiee_pkg::PUR_MAX_CYC,
    parameter int PUW_CYC_P = spiee_pkg::PUW_MAX_CYC,
    parameter int TWC_CYC_P = spiee_pkg::TWC_MAX_CYC
) (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    spiee_if.dev       link,
    output wire logic  write_busy_o,
    output wire logic  write_latch_o,
    output wire logic  ready_o
);
    import spiee_pkg::*;

    localparam logic [TMR_W-1:0] PUR_L = TMR_W'(PUR_CYC_P);
    localparam logic [TMR_W-1:0] PUW_L = TMR_W'(PUW_CYC_P);
    localparam logic [TMR_W-1:0] TWC_L = TMR_W'(TWC_CYC_P - 1);

    typedef struct packed {
        logic [6:0]      cnt;
        logic [2:0]      ph;
        logic [7:0]      sh;
        logic [7:0]      op;
        logic [7:0]      addr;
        logic [7:0]      rd_addr;
        logic [3:0][7:0] pbuf;
        logic [3:0]      pval;
        logic [7:0]      out_sr;
        logic            drive;
        logic [4:0]      sy1;
        logic [4:0]      sy2;
    } spiee_lnk_type;

    typedef struct packed {
        logic             cs1;
        logic             cs2;
        logic             cs3;
        logic             wp1;
        logic             wp2;
        logic [TMR_W-1:0] por;
        logic             rd_ok;
        logic             wr_ok;
        logic             armed;
        logic             rdy;
        logic             frame;
        logic             write_latch_flag;
        logic [1:0]       bl;
        logic             write_busy_flag;
        logic             is_stat;
        logic [TMR_W-1:0] wc;
        logic [7:0]       caddr;
        logic [3:0][7:0]  cbuf;
        logic [3:0]       cval;
        logic [1:0]       cbl;
    } spiee_sys_type;

    spiee_lnk_type l_q;
    spiee_lnk_type l_d;
    spiee_lnk_type cur;
    spiee_sys_type s_q;
    spiee_sys_type s_d;
    logic          started_q;
    logic          so_q;
    logic [7:0]    mem_q [256];
    logic [7:0]    nxt;
    logic [6:0]    newc;
    logic [1:0]    slot;
    logic [7:0]    status;
    logic          ok_w;
    logic          locked;
    logic          cnt_ok;
    logic          wc_end;

    // link side: first edge after select falls starts a fresh frame
    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            started_q <= 1'b0;
        end else if (link.hold_n) begin
            started_q <= 1'b1;
        end
    end

    always_comb begin
        cur = l_q;
        if (!started_q) begin
            cur.cnt    = '0;
            cur.ph     = '0;
            cur.op     = '0;
            cur.pval   = '0;
            cur.drive  = 1'b0;
            cur.out_sr = '0;
        end
        l_d     = cur;
        l_d.sy1 = {s_q.rdy, s_q.bl, s_q.write_latch_flag, s_q.write_busy_flag};
        l_d.sy2 = l_q.sy1;
        nxt     = {cur.sh[6:0], link.si};
        newc    = (cur.cnt == CNT_SAT) ? CNT_SAT : 7'(cur.cnt + 7'h01);
        slot    = 2'(cur.addr[1:0] + newc[4:3] + 2'h1);
        status  = l_q.sy2[ST_BUSY_BIT] ? ST_ALL_BUSY
                                       : {4'h0, l_q.sy2[3:2], l_q.sy2[1], l_q.sy2[0]};
        // pause freezes the sequence without losing it
        if (link.hold_n) begin
            l_d.sh     = nxt;
            l_d.cnt    = newc;
            l_d.ph     = 3'(cur.ph + 3'h1);
            l_d.out_sr = {cur.out_sr[6:0], 1'b0};
            if (cur.ph == 3'h7) begin
                if (newc == CNT_OPCODE) begin
                    l_d.op = nxt;
                    if (nxt == OP_READ_STATUS && l_q.sy2[4]) begin
                        l_d.out_sr = status;
                        l_d.drive  = 1'b1;
                    end
                // status reads keep repeating past the address slot
                end else if (newc == CNT_ADDR && cur.op != OP_READ_STATUS) begin
                    l_d.addr = nxt;
                    if (cur.op == OP_READ_ARRAY && l_q.sy2[4]) begin
                        l_d.out_sr  = mem_q[nxt];
                        l_d.rd_addr = 8'(nxt + 8'h01);
                        l_d.drive   = 1'b1;
                    end
                end else if (cur.op == OP_READ_ARRAY && cur.drive) begin
                    l_d.out_sr  = mem_q[cur.rd_addr];
                    l_d.rd_addr = 8'(cur.rd_addr + 8'h01);
                end else if (cur.op == OP_READ_STATUS && cur.drive) begin
                    l_d.out_sr = status;
                end else if (cur.op == OP_WRITE_ARRAY) begin
                    // page wrap overwrites earlier bytes
                    l_d.pbuf[slot] = nxt;
                    l_d.pval[slot] = 1'b1;
                end
            end
        end
    end

    // frame fields stay unreset: started_q masks stale ones
    always_ff @(posedge link.sck) begin
        l_q <= l_d;
    end

    always_ff @(negedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            so_q <= 1'b0;
        end else if (link.hold_n) begin
            so_q <= l_q.out_sr[7];
        end
    end

    // drive only during a selected read
    assign link.so_oe_n = ~(started_q & l_q.drive & link.hold_n & ~link.cs_n);
    assign link.so_d    = so_q;

    // system side
    always_comb begin
        s_d     = s_q;
        s_d.cs1 = link.cs_n;
        s_d.cs2 = s_q.cs1;
        s_d.cs3 = s_q.cs2;
        s_d.wp1 = link.wp_n;
        s_d.wp2 = s_q.wp1;
        if (s_q.por != PUW_L) begin
            s_d.por = TMR_W'(s_q.por + 1'b1);
        end
        s_d.rd_ok = (s_q.por >= PUR_L);
        s_d.wr_ok = (s_q.por >= PUW_L);
        // wake only on a fresh select fall
        if (s_q.cs2 && s_q.rd_ok) begin
            s_d.armed = 1'b1;
        end
        s_d.rdy = s_q.armed & s_q.rd_ok;
        // link fields are static here: select is high and the link clock stopped
        ok_w   = s_q.write_latch_flag & s_q.wp2 & ~s_q.write_busy_flag & s_q.wr_ok;
        locked = (l_q.addr >= LOCK_QTR && s_q.bl == 2'h1)
               | (l_q.addr >= LOCK_HALF && s_q.bl == 2'h2) | (s_q.bl == 2'h3);
        cnt_ok = (l_q.cnt == CNT_W1) | (l_q.cnt == CNT_W2)
               | (l_q.cnt == CNT_W3) | (l_q.cnt == CNT_W4);
        if (!s_q.cs2 && s_q.cs3) begin
            s_d.frame = s_q.armed;
        end
        if (s_q.cs2 && !s_q.cs3 && s_q.frame) begin
            s_d.frame = 1'b0;
            if (l_q.cnt == CNT_OPCODE && l_q.op == OP_SET_LATCH) begin
                // only this opcode sets the latch
                s_d.write_latch_flag = s_q.wp2 & ~s_q.write_busy_flag & s_q.wr_ok ? 1'b1 : s_q.write_latch_flag;
            end else if (l_q.cnt == CNT_OPCODE && l_q.op == OP_CLR_LATCH && !s_q.write_busy_flag) begin
                s_d.write_latch_flag = 1'b0;
            end else if (l_q.op == OP_WRITE_STAT && l_q.cnt == CNT_ADDR && ok_w) begin
                s_d.write_busy_flag     = 1'b1;
                s_d.is_stat = 1'b1;
                s_d.cbl     = l_q.addr[ST_LOCK_LSB +: 2];
                s_d.wc      = '0;
            // commit only at a valid count
            end else if (l_q.op == OP_WRITE_ARRAY && cnt_ok && ok_w && !locked) begin
                s_d.write_busy_flag     = 1'b1;
                s_d.is_stat = 1'b0;
                s_d.caddr   = l_q.addr;
                s_d.cbuf    = l_q.pbuf;
                s_d.cval    = l_q.pval;
                s_d.wc      = '0;
            end
        end
        wc_end = s_q.write_busy_flag && (s_q.wc == TWC_L);
        if (s_q.write_busy_flag) begin
            s_d.wc = TMR_W'(s_q.wc + 1'b1);
        end
        if (wc_end) begin
            s_d.write_busy_flag = 1'b0;
            s_d.write_latch_flag = 1'b0;
            if (s_q.is_stat) begin
                s_d.bl = s_q.cbl;
            end
        end
        // protect low wins over any set
        if (!s_q.wp2) begin
            s_d.write_latch_flag = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // array contents survive reset, as nonvolatile storage does
    always_ff @(posedge clk_i) begin
        if (!rst_i && wc_end && !s_q.is_stat) begin
            for (int i = 0; i < 4; i++) begin
                if (s_q.cval[i]) begin
                    mem_q[{s_q.caddr[7:2], 2'(i)}] <= s_q.cbuf[i];
                end
            end
        end
    end

    assign write_busy_o  = s_q.write_busy_flag;
    assign write_latch_o = s_q.write_latch_flag;
    assign ready_o       = s_q.wr_ok;
endmodule // spiee_device

// ---- core/spiee_pkg.sv ----
/*
 * Shared constants for the serial EEPROM write-guard link: power-up and
 * write-cycle timing, opcodes, status layout, clock counts and host registers.
 * Assumes a 125 MHz system clock on both ends.
 */
package spiee_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int NS_PER_MS     = 1000000;
    localparam int PUR_MS        = 1;
    localparam int PUW_MS        = 5;
    localparam int TWC_MS        = 10;
    localparam int SCK_HALF_NS   = 500;
    // device limits are longest times: round down
    localparam int PUR_MAX_CYC   = PUR_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int PUW_MAX_CYC   = PUW_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int TWC_MAX_CYC   = TWC_MS * NS_PER_MS / CLK_PERIOD_NS;
    // host waits are least times: round up
    localparam int PUR_MIN_CYC   = (PUR_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PUW_MIN_CYC   = (PUW_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TWC_MIN_CYC   = (TWC_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W         = 21;

    localparam logic [7:0] OP_SET_LATCH   = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH   = 8'h04;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_STAT  = 8'h01;
    localparam logic [7:0] OP_READ_ARRAY  = 8'h03;
    localparam logic [7:0] OP_WRITE_ARRAY = 8'h02;

    localparam logic [6:0] CNT_OPCODE = 7'h08;
    localparam logic [6:0] CNT_ADDR   = 7'h10;
    localparam logic [6:0] CNT_W1     = 7'h18;
    localparam logic [6:0] CNT_W2     = 7'h20;
    localparam logic [6:0] CNT_W3     = 7'h28;
    localparam logic [6:0] CNT_W4     = 7'h30;
    localparam logic [6:0] CNT_SAT    = 7'h7F;

    localparam int         ST_BUSY_BIT  = 0;
    localparam int         ST_LATCH_BIT = 1;
    localparam int         ST_LOCK_LSB  = 2;
    localparam logic [7:0] ST_ALL_BUSY  = 8'hFF;
    localparam logic [7:0] LOCK_QTR     = 8'hC0;
    localparam logic [7:0] LOCK_HALF    = 8'h80;

    localparam logic [7:0]  REG_CTRL = 8'h00;
    localparam logic [7:0]  REG_TXA  = 8'h04;
    localparam logic [7:0]  REG_TXB  = 8'h08;
    localparam logic [7:0]  REG_STAT = 8'h0C;
    localparam logic [7:0]  REG_RX   = 8'h10;
    localparam int          CTRL_WP_BIT    = 8;
    localparam int          CTRL_HOLD_BIT  = 9;
    localparam int          CTRL_START_BIT = 16;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0300;
    localparam logic [31:0] CTRL_MASK      = 32'h0000_033F;
    localparam logic [5:0]  MAX_BITS       = 6'h30;

    function automatic logic [31:0] spiee_merge(input logic [31:0] old,
                                                input logic [31:0] wd,
                                                input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction
endpackage

// ---- core/spiee_if.sv ----
/*
 * Link between the serial EEPROM end and its host end.
 * Assumes an idle data-out line pulled high when the device does not drive it.
 */
`timescale 1ns/1ps
interface spiee_if;
    logic sck;
    logic cs_n;
    logic si;
    logic wp_n;
    logic hold_n;
    logic so_d;
    logic so_oe_n;
    logic so;

    // pull-up when undriven
    assign so = so_oe_n ? 1'b1 : so_d;

    modport dev  (input sck, input cs_n, input si, input wp_n, input hold_n,
                  output so_d, output so_oe_n);
    modport host (output sck, output cs_n, output si, output wp_n, output hold_n,
                  input so);
endinterface

// ---- core/spiee_host.sv ----
/*
 * Host end: Wishbone classic slave registers that run one select frame of
 * up to 48 bits, making the link clock by dividing clk_i.
 * Assumes rst_i at power-up, same moment as the device's power-on.
 */
`timescale 1ns/1ps
module spiee_host #(
    parameter int PUR_CYC_P = spiee_pkg::PUR_MIN_CYC,
    parameter int PUW_CYC_P = spiee_pkg::PUW_MIN_CYC,
    parameter int TWC_CYC_P = spiee_pkg::TWC_MIN_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output wire logic [31:0] wb_dat_o,
    output wire logic        wb_ack_o,
    spiee_if.host            link
);
    import spiee_pkg::*;

    localparam logic [TMR_W-1:0] PUR_L  = TMR_W'(PUR_CYC_P);
    localparam logic [TMR_W-1:0] PUW_L  = TMR_W'(PUW_CYC_P);
    localparam logic [TMR_W-1:0] TWC_L  = TMR_W'(TWC_CYC_P - 1);
    localparam logic [5:0]       HALF_L = 6'(SCK_HALF_CYC - 1);

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LEAD = 3'b001,
        H_HIGH = 3'b010,
        H_LOW  = 3'b011,
        H_LAG  = 3'b100,
        H_GAP  = 3'b101
    } spiee_hst_type;

    typedef struct packed {
        spiee_hst_type    st;
        logic [5:0]       half;
        logic [5:0]       left;
        logic [47:0]      tx;
        logic [31:0]      rx;
        logic [31:0]      ctrl;
        logic [31:0]      txa;
        logic [31:0]      txb;
        logic             refused;
        logic [TMR_W-1:0] por;
        logic [TMR_W-1:0] gap;
        logic             rd_ok;
        logic             wr_ok;
        logic             gap_on;
        logic             was_wr;
        logic             so1;
        logic             so2;
        logic             sck;
        logic             cs_n;
        logic             si;
        logic             hold;
        logic             ack;
        logic [31:0]      dat;
    } spiee_hreg_type;

    spiee_hreg_type q;
    spiee_hreg_type n;
    logic           req;
    logic           go;
    logic           wr_cls;
    logic           half_done;
    logic [31:0]    ctrl_w;
    logic [5:0]     nb;

    always_comb begin
        n      = q;
        n.so1  = link.so;
        n.so2  = q.so1;
        n.ack  = 1'b0;
        req    = wb_cyc_i & wb_stb_i & ~q.ack;
        ctrl_w = spiee_merge(q.ctrl, wb_dat_i, wb_sel_i);
        nb     = ctrl_w[5:0];
        go     = req & wb_we_i & (wb_adr_i == REG_CTRL) & wb_sel_i[2] & wb_dat_i[CTRL_START_BIT];
        wr_cls = (q.txa[31:24] == OP_SET_LATCH) | (q.txa[31:24] == OP_WRITE_STAT)
               | (q.txa[31:24] == OP_WRITE_ARRAY);
        if (q.por != PUW_L) begin
            n.por = TMR_W'(q.por + 1'b1);
        end
        n.rd_ok = (q.por >= PUR_L);
        n.wr_ok = (q.por >= PUW_L);
        if (q.gap_on) begin
            n.gap    = TMR_W'(q.gap + 1'b1);
            n.gap_on = (q.gap != TWC_L);
        end
        if (req) begin
            n.ack = 1'b1;
            if (wb_we_i) begin
                case (wb_adr_i)
                    REG_CTRL: n.ctrl = ctrl_w & CTRL_MASK;
                    REG_TXA:  n.txa  = spiee_merge(q.txa, wb_dat_i, wb_sel_i);
                    REG_TXB:  n.txb  = spiee_merge(q.txb, wb_dat_i, wb_sel_i);
                    default:  n.dat  = q.dat;
                endcase
            end else begin
                case (wb_adr_i)
                    REG_CTRL: n.dat = q.ctrl;
                    REG_TXA:  n.dat = q.txa;
                    REG_TXB:  n.dat = q.txb;
                    REG_STAT: n.dat = {27'h0, q.refused, q.gap_on, q.wr_ok, q.rd_ok,
                                       (q.st != H_IDLE)};
                    REG_RX:   n.dat = q.rx;
                    default:  n.dat = 32'h0000_0000;
                endcase
            end
        end
        if (go) begin
            if (q.st == H_IDLE && nb != 6'h00 && nb <= MAX_BITS
                && (wr_cls ? (q.wr_ok & ~q.gap_on) : q.rd_ok)) begin
                // select falls before the first clock
                n.st      = H_LEAD;
                n.cs_n    = 1'b0;
                n.half    = '0;
                n.left    = nb;
                n.tx      = {q.txa, q.txb[31:16]};
                n.si      = q.txa[31];
                n.was_wr  = (q.txa[31:24] == OP_WRITE_STAT) | (q.txa[31:24] == OP_WRITE_ARRAY);
                n.refused = 1'b0;
            end else begin
                n.refused = 1'b1;
            end
        end
        half_done = (q.half == HALF_L);
        if (q.st != H_IDLE && q.hold) begin
            n.half = half_done ? 6'h00 : 6'(q.half + 6'h01);
            case (q.st)
                H_LEAD: begin
                    if (half_done) begin
                        n.st  = H_HIGH;
                        n.sck = 1'b1;
                    end
                end
                H_HIGH: begin
                    if (half_done) begin
                        n.sck  = 1'b0;
                        n.rx   = {q.rx[30:0], q.so2};
                        n.tx   = {q.tx[46:0], 1'b0};
                        n.si   = q.tx[46];
                        n.left = 6'(q.left - 6'h01);
                        // select rises after the asked count
                        n.st   = (q.left == 6'h01) ? H_LAG : H_LOW;
                    end
                end
                H_LOW: begin
                    if (half_done) begin
                        n.st  = H_HIGH;
                        n.sck = 1'b1;
                    end
                end
                H_LAG: begin
                    if (half_done) begin
                        n.cs_n = 1'b1;
                        n.st   = H_GAP;
                        if (q.was_wr) begin
                            n.gap_on = 1'b1;
                            n.gap    = '0;
                        end
                    end
                end
                H_GAP: begin
                    if (half_done) begin
                        n.st = H_IDLE;
                    end
                end
                default: n.st = H_IDLE;
            endcase
        end
        // pause moves only while the clock stays low
        // a rise in the same cycle would freeze the frame with the clock high
        if (!q.sck && !n.sck) begin
            n.hold = q.ctrl[CTRL_HOLD_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q      <= '0;
            q.cs_n <= 1'b1;
            q.so1  <= 1'b1;
            q.so2  <= 1'b1;
            q.hold <= 1'b1;
            q.ctrl <= CTRL_RESET;
        end else begin
            q <= n;
        end
    end

    assign wb_dat_o    = q.dat;
    assign wb_ack_o    = q.ack;
    assign link.sck    = q.sck;
    assign link.cs_n   = q.cs_n;
    assign link.si     = q.si;
    // protect pin follows control bit 8, high from reset so latch can set
    assign link.wp_n   = q.ctrl[CTRL_WP_BIT];
    assign link.hold_n = q.hold;
endmodule // spiee_host

// ---- sim/spiee_assertions.sv ----
/*
 * Link checker: select, clock, data, pause and output-enable timing.
 * Assumes one clk_i domain, rst_i synchronous and active high.
 */
`timescale 1ns/1ps
module spiee_assertions (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    input  wire logic hold_n,
    input  wire logic so_oe_n
);
    typedef struct packed {
        logic [6:0] hi;
        logic [6:0] lo;
        logic [6:0] des;
    } spiee_cnt_type;
    spiee_cnt_type cnt_q;
    spiee_cnt_type cnt_d;

    // saturating, so long idle spans never wrap to a short count
    always_comb begin
        cnt_d     = cnt_q;
        cnt_d.hi  = sck ? cnt_q.hi + {6'h00, cnt_q.hi != 7'h7F} : 7'h00;
        cnt_d.lo  = (sck || cs_n) ? 7'h00 : cnt_q.lo + {6'h00, cnt_q.lo != 7'h7F};
        cnt_d.des = cs_n ? cnt_q.des + {6'h00, cnt_q.des != 7'h7F} : 7'h00;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence desel_s;
        cs_n [*8];
    endsequence

    idle_clk_low_a: assert property (cs_n |-> !sck)
        else $error("link clock high while deselected");
    out_float_a: assert property (desel_s |-> so_oe_n)
        else $error("data out driven while deselected");
    out_release_a: assert property ($rose(cs_n) |-> ##[0:62] so_oe_n)
        else $error("data out not released after select rise");
    high_time_a: assert property ($fell(sck) |-> cnt_q.hi >= 7'h32)
        else $error("link clock high phase too short");
    low_time_a: assert property ($rose(sck) |-> cnt_q.lo >= 7'h32)
        else $error("link clock low phase or lead too short");
    si_stable_a: assert property (sck && $past(sck) |-> $stable(si))
        else $error("data in changed while clock high");
    deselect_a: assert property ($fell(cs_n) |-> cnt_q.des >= 7'h3F)
        else $error("select high time too short");
    pause_low_a: assert property ($changed(hold_n) |-> !sck && !$past(sck))
        else $error("pause changed while clock high");
endmodule // spiee_assertions

// ---- sim/spi_eeprom_write_guard_bench.sv ----
/*
 * Bench: host and device joined by the link, driven through Wishbone calls.
 * Assumes shortened power-up and write-cycle counts to keep the run brief.
 */
`timescale 1ns/1ps
module spi_eeprom_write_guard_bench;
    import spiee_pkg::*;
    localparam int PUR_C = 200;
    localparam int PUW_C = 500;
    localparam int TWC_C = 4000;
    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [31:0] rd_dat;
    logic        ack;
    logic [31:0] rd;
    logic        busy;
    logic        latch;
    logic        ready;
    int          mismatches;
    int          check_count;
    int          cycles;

    spiee_if lnk ();
    spiee_host #(.PUR_CYC_P(PUR_C), .PUW_CYC_P(PUW_C), .TWC_CYC_P(TWC_C)) u_spiee_host (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rd_dat),
        .wb_ack_o(ack), .link(lnk.host));
    spiee_device #(.PUR_CYC_P(PUR_C), .PUW_CYC_P(PUW_C), .TWC_CYC_P(TWC_C)) u_spiee_device (
        .clk_i(clk_i), .rst_i(rst_i), .link(lnk.dev), .write_busy_o(busy),
        .write_latch_o(latch), .ready_o(ready));
    spiee_assertions u_spiee_assertions (.clk_i(clk_i), .rst_i(rst_i), .sck(lnk.sck),
        .cs_n(lnk.cs_n), .si(lnk.si), .hold_n(lnk.hold_n), .so_oe_n(lnk.so_oe_n));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ceiling well above the roughly 40000 cycles the sequence needs
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = rd_dat;
        {cyc, stb} <= 2'h0;
    endtask

    task automatic stat_wait(input int b, input logic v);
        do wb(1'b0, REG_STAT, 32'h0); while (rd[b] !== v);
    endtask

    // one whole frame, then wait until the host reports it idle
    task automatic frame(input logic [31:0] a, input logic [5:0] n);
        wb(1'b1, REG_TXA, a);
        wb(1'b1, REG_TXB, 32'h0);
        wb(1'b1, REG_CTRL, 32'h0001_0300 | {26'h0, n});
        stat_wait(0, 1'b0);
        repeat (16) @(posedge clk_i);
    endtask

    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, adr, dat} = '0;
        mismatches = 0;
        check_count = 0;
        cycles = 0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("so_oe_n", 32'h1, lnk.so_oe_n);
        chk("latch", 32'h0, latch);
        frame(32'h0310_0000, 6'h18);
        wb(1'b0, REG_STAT, 32'h0);
        chk("refused", 32'h1, rd[4]);
        chk("cs_n", 32'h1, lnk.cs_n);
        stat_wait(2, 1'b1);
        repeat (4) @(posedge clk_i);
        chk("ready", 32'h1, ready);
        frame(32'h0600_0000, 6'h08);
        chk("latch", 32'h1, latch);
        frame(32'h0400_0000, 6'h08);
        chk("latch", 32'h0, latch);
        frame(32'h0600_0000, 6'h08);
        frame(32'h0220_5A00, 6'h14);
        chk("busy", 32'h0, busy);
        stat_wait(3, 1'b0);
        frame(32'h0600_0000, 6'h08);
        frame(32'h0210_A500, 6'h18);
        chk("busy", 32'h1, busy);
        frame(32'h0500_0000, 6'h10);
        wb(1'b0, REG_RX, 32'h0);
        chk("status", 32'hFF, rd[7:0]);
        for (int i = 0; i < TWC_C && busy === 1'b1; i++) @(posedge clk_i);
        chk("busy", 32'h0, busy);
        chk("latch", 32'h0, latch);
        frame(32'h0500_0000, 6'h10);
        wb(1'b0, REG_RX, 32'h0);
        chk("status", 32'h0, rd[3:0]);
        frame(32'h0310_0000, 6'h18);
        wb(1'b0, REG_RX, 32'h0);
        chk("data", 32'hA5, rd[7:0]);
        stat_wait(3, 1'b0);
        frame(32'h0600_0000, 6'h08);
        chk("latch", 32'h1, latch);
        wb(1'b1, REG_CTRL, 32'h0);
        repeat (8) @(posedge clk_i);
        chk("latch", 32'h0, latch);
        wb(1'b1, REG_CTRL, CTRL_RESET);
        // quarter lock through a status write, then a refused locked write
        frame(32'h0600_0000, 6'h08);
        frame(32'h0104_0000, 6'h10);
        chk("busy", 32'h1, busy);
        stat_wait(3, 1'b0);
        frame(32'h0500_0000, 6'h10);
        wb(1'b0, REG_RX, 32'h0);
        chk("status", 32'h04, rd[7:0]);
        frame(32'h0600_0000, 6'h08);
        chk("latch", 32'h1, latch);
        frame(32'h02C0_1100, 6'h18);
        chk("busy", 32'h0, busy);
        print_verdict();
    end
endmodule // spi_eeprom_write_guard_bench
